// *** rtl/adcss_cfg.svh ***
`ifndef ADCSS_CFG_SVH
`define ADCSS_CFG_SVH
// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define ADCSS_IDX_CTL_LAST 6'h04
`define ADCSS_IDX_MODE 6'h03
`define ADCSS_IDX_START 6'h05
`define ADCSS_IDX_STATUS 6'h06
`define ADCSS_IDX_CMPE 6'h08
`define ADCSS_IDX_CCF 6'h0A
`define ADCSS_IDX_COMPARE_HIGHER_SELECT 6'h0E
`define ADCSS_IDX_RESULT0 6'h10
// ****************************************
// Status field positions
// ****************************************
`define ADCSS_BIT_DONE 7
`define ADCSS_BIT_TRIG_OVR 5
`define ADCSS_BIT_RES_OVR 4
// ****************************************
// Mode register fields and reset value
// ****************************************
`define ADCSS_BIT_SCAN 0
`define ADCSS_BIT_QUEUE 1
`define ADCSS_BIT_AUTO_FLAG_CLEAR 2
`define ADCSS_BIT_TRIG_LEVEL 3
`define ADCSS_BIT_TRIG_EN 4
`define ADCSS_LEN_LSB 8
`define ADCSS_MODE_RESET 16'h0100
// ****************************************
// Bus responses
// ****************************************
`define ADCSS_RESP_OKAY 2'h0
`define ADCSS_RESP_SLVERR 2'h2
`endif

// *** rtl/adcss_pkg.sv ***
package adcss_pkg;
    typedef logic [3:0] adcss_cnt_t;
    typedef logic [5:0] adcss_idx_t;
    typedef enum {rd_idle, rd_fetch, rd_load, rd_resp} adcss_rd_e;
endpackage : adcss_pkg

// *** rtl/adcss_result_mem.sv ***
`timescale 1ns/100ps
`default_nettype none
module adcss_result_mem #(
    parameter int DEPTH = 10,
    parameter int WIDTH = 16
) (
    input wire logic clk,
    input wire logic we,
    input wire adcss_pkg::adcss_cnt_t waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [WIDTH/8-1:0] wbe,
    input wire adcss_pkg::adcss_cnt_t ra_addr,
    output logic [WIDTH-1:0] ra_data,
    input wire adcss_pkg::adcss_cnt_t rb_addr,
    output logic [WIDTH-1:0] rb_data
);
    import adcss_pkg::*;
    if (WIDTH % 8 != 0 || DEPTH > 16) begin : g_bad
        $error("adcss_result_mem: unsupported size");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    // ****************************************
    // Byte-lane writes
    // ****************************************
    always_ff @(posedge clk) begin
        for (int b = 0; b < WIDTH / 8; b++) begin
            if (we && wbe[b] && int'(waddr) < DEPTH) begin
                mem[waddr][8*b +: 8] <= wdata[8*b +: 8];
            end
        end
    end
    // ****************************************
    // Registered reads, zero outside the array
    // ****************************************
    always_ff @(posedge clk) begin
        ra_data <= (int'(ra_addr) < DEPTH) ? mem[ra_addr] : '0;
        rb_data <= (int'(rb_addr) < DEPTH) ? mem[rb_addr] : '0;
    end
endmodule : adcss_result_mem
`default_nettype wire

// *** rtl/adcss_trig_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module adcss_trig_sync (
    input wire logic clk,
    input wire logic resetn,
    input wire logic pin,
    output logic level,
    output logic rise
);
    logic [2:0] sync;
    logic [2:0] next_sync;
    always_comb begin
        next_sync = {sync[1:0], pin};
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sync <= 3'h0;
        end else begin
            sync <= next_sync;
        end
    end
    // Only the second stage and its delayed copy feed logic
    assign level = sync[1];
    assign rise = sync[1] & ~sync[2];
endmodule : adcss_trig_sync
`default_nettype wire

// *** rtl/adcss_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "adcss_cfg.svh"
// Overview of operation
// RQ1: The sequence done flag sets when a sequence ends, again after each one in scan mode.
// RQ2: It clears on a 1 written to it, any start write, or a result read with auto clear.
// RQ3: In edge trigger mode a trigger edge during a running sequence sets trigger overrun.
// RQ4: Trigger overrun clears on a 1 written or any control, compare or start write.
// RQ5: Result overrun sets when a result slot is stored while its complete flag is set.
// RQ6: Result overrun clears on a 1 written or any control, compare or start write.
// RQ7: A 4-bit read-only counter in status bits 3 to 0 points at the receiving slot.
// RQ8: Outside queue mode the counter returns to zero at sequence start and end.
// RQ9: In queue mode the counter runs on across sequences and wraps at its maximum.
// RQ10: An abort or an explicit start clears the counter in every mode.
// RQ11: Any write to the compare enable register aborts the running sequence.
// RQ12: One compare enable per conversion position 0 to 9 selects automatic compare.
// RQ13: Software loads the compare value into the slot, then picks the operator.
// RQ14: For compare positions the complete flag reports a successful compare.
// RQ15: Operator 0 passes on result lower or equal, operator 1 on result strictly higher.
// RQ16: A compared result is discarded and the slot keeps the compare value.
// RQ17: Unused status and compare enable bits read zero and ignore writes.
module adcss_top #(
    parameter int NUM_RESULTS = 10,
    parameter int RESULT_W = 10
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic trig_pin,
    input wire logic conv_done,
    input wire logic [RESULT_W-1:0] conv_result,
    output logic seq_busy,
    output var adcss_pkg::adcss_cnt_t conversion_counter
);
    import adcss_pkg::*;
    if (NUM_RESULTS < 1 || NUM_RESULTS > 16 || RESULT_W < 1 || RESULT_W > 16) begin : g_bad
        $error("adcss_top: unsupported parameters");
    end
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic is_result(input adcss_idx_t idx);
        return int'(idx) >= int'(`ADCSS_IDX_RESULT0)
            && int'(idx) < int'(`ADCSS_IDX_RESULT0) + NUM_RESULTS;
    endfunction : is_result
    function automatic logic is_mapped(input adcss_idx_t idx);
        return is_result(idx) || idx <= `ADCSS_IDX_CTL_LAST || idx == `ADCSS_IDX_START
            || idx == `ADCSS_IDX_STATUS || idx == `ADCSS_IDX_CMPE
            || idx == `ADCSS_IDX_CCF || idx == `ADCSS_IDX_COMPARE_HIGHER_SELECT;
    endfunction : is_mapped
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] mask;
        mask = '0;
        for (int i = 0; i < 4; i++) begin
            mask[8*i +: 8] = {8{strb[i]}};
        end
        return (old & ~mask) | (data & mask);
    endfunction : merge
    // ****************************************
    // State
    // ****************************************
    logic aw_held, next_aw_held, w_held, next_w_held, next_seq_busy;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic sequence_done_flag, next_sequence_done_flag, pend_valid, next_pend_valid;
    logic trigger_overrun_flag, next_trigger_overrun_flag;
    logic result_overrun_flag, next_result_overrun_flag;
    logic [NUM_RESULTS-1:0] compare_enable_bits, next_compare_enable_bits;
    logic [NUM_RESULTS-1:0] compare_higher_select, next_compare_higher_select;
    logic [NUM_RESULTS-1:0] conversion_complete_flag, next_conversion_complete_flag;
    logic [31:0] w_data, next_w_data, next_rdata, rd_word;
    logic [15:0] mode, next_mode, pend_data, next_pend_data, ra_data, rb_data, mem_wdata;
    logic [3:0] w_strb, next_w_strb, len_field;
    logic [1:0] next_bresp, next_rresp, mem_wbe;
    adcss_idx_t aw_idx, next_aw_idx, ar_idx, next_ar_idx;
    adcss_rd_e rd_state, next_rd_state;
    adcss_cnt_t next_conversion_counter, pos, next_pos, seq_len, res_sel_w, res_sel_r, mem_waddr;
    logic wr_fire, start_wr, abort_wr, res_wr, res_rd, store_now, in_range, cmp_hit, mem_we;
    logic trig_level, trig_rise, trig_go, auto_flag_clear, queue_mode;
    logic [7:0] status_w1c;
    adcss_trig_sync u_trig (
        .clk(aclk), .resetn(aresetn), .pin(trig_pin), .level(trig_level), .rise(trig_rise)
    );
    adcss_result_mem #(.DEPTH(NUM_RESULTS), .WIDTH(16)) u_mem (
        .clk(aclk), .we(mem_we), .waddr(mem_waddr), .wdata(mem_wdata), .wbe(mem_wbe),
        .ra_addr(res_sel_r), .ra_data(ra_data), .rb_addr(conversion_counter), .rb_data(rb_data)
    );
    // Bus writes wait while a conversion result is being stored
    assign wr_fire = aw_held & w_held & ~s_axi_bvalid & ~pend_valid;
    assign start_wr = wr_fire && aw_idx == `ADCSS_IDX_START;
    assign abort_wr = wr_fire && (aw_idx <= `ADCSS_IDX_CTL_LAST
        || aw_idx == `ADCSS_IDX_CMPE || aw_idx == `ADCSS_IDX_COMPARE_HIGHER_SELECT); // [RQ11]
    assign res_wr = wr_fire && is_result(aw_idx);
    assign res_sel_w = adcss_cnt_t'(aw_idx - `ADCSS_IDX_RESULT0);
    assign res_sel_r = adcss_cnt_t'(ar_idx - `ADCSS_IDX_RESULT0);
    assign res_rd = rd_state == rd_load && is_result(ar_idx);
    assign status_w1c = (wr_fire && aw_idx == `ADCSS_IDX_STATUS && w_strb[0])
        ? w_data[7:0] : 8'h00;
    assign auto_flag_clear = mode[`ADCSS_BIT_AUTO_FLAG_CLEAR];
    assign queue_mode = mode[`ADCSS_BIT_QUEUE];
    assign len_field = mode[`ADCSS_LEN_LSB +: 4];
    assign seq_len = (len_field == 4'h0 || int'(len_field) > NUM_RESULTS)
        ? adcss_cnt_t'(NUM_RESULTS) : len_field;
    assign trig_go = mode[`ADCSS_BIT_TRIG_EN] & ~seq_busy
        & (mode[`ADCSS_BIT_TRIG_LEVEL] ? trig_level : trig_rise);
    assign store_now = pend_valid & seq_busy & ~abort_wr & ~start_wr;
    assign in_range = int'(conversion_counter) < NUM_RESULTS;
    // Operator 0: lower or same; operator 1: strictly higher
    assign cmp_hit = in_range && (compare_higher_select[conversion_counter]
        ? pend_data > rb_data : pend_data <= rb_data); // [RQ15]
    // ****************************************
    // Result slot writes
    // ****************************************
    always_comb begin
        mem_we = 1'b0;
        mem_waddr = conversion_counter;
        mem_wdata = pend_data;
        mem_wbe = 2'h3;
        if (store_now) begin
            // Compared results are dropped, the slot keeps its compare value
            mem_we = in_range && !compare_enable_bits[conversion_counter]; // [RQ16]
        end else if (res_wr) begin
            mem_we = 1'b1;
            mem_waddr = res_sel_w;
            mem_wdata = w_data[15:0];
            mem_wbe = w_strb[1:0];
        end
    end
    // ****************************************
    // Read data
    // ****************************************
    always_comb begin
        rd_word = 32'h0000_0000;
        if (is_result(ar_idx)) begin
            rd_word[15:0] = ra_data;
        end else begin
            unique case (ar_idx)
                `ADCSS_IDX_STATUS: begin
                    rd_word[`ADCSS_BIT_DONE] = sequence_done_flag;
                    rd_word[`ADCSS_BIT_TRIG_OVR] = trigger_overrun_flag;
                    rd_word[`ADCSS_BIT_RES_OVR] = result_overrun_flag;
                    rd_word[3:0] = conversion_counter; // [RQ7]
                end
                `ADCSS_IDX_CMPE: rd_word[NUM_RESULTS-1:0] = compare_enable_bits; // [RQ17]
                `ADCSS_IDX_COMPARE_HIGHER_SELECT: rd_word[NUM_RESULTS-1:0] = compare_higher_select;
                `ADCSS_IDX_CCF: rd_word[NUM_RESULTS-1:0] = conversion_complete_flag;
                `ADCSS_IDX_MODE: rd_word[15:0] = mode;
                default: rd_word = 32'h0000_0000;
            endcase
        end
    end
    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_aw_held = aw_held;
        next_aw_idx = aw_idx;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rd_state = rd_state;
        next_ar_idx = ar_idx;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        next_mode = mode;
        next_compare_enable_bits = compare_enable_bits;
        next_compare_higher_select = compare_higher_select;
        next_seq_busy = seq_busy;
        next_conversion_counter = conversion_counter;
        next_pos = pos;
        next_pend_valid = 1'b0;
        next_pend_data = pend_data;
        next_sequence_done_flag = 1'b0;
        next_result_overrun_flag = 1'b0;
        next_trigger_overrun_flag = 1'b0;
        next_conversion_complete_flag = '0;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_idx = s_axi_awaddr[7:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (wr_fire) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = is_mapped(aw_idx) ? `ADCSS_RESP_OKAY : `ADCSS_RESP_SLVERR;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        next_awready = ~next_aw_held & ~next_bvalid;
        next_wready = ~next_w_held & ~next_bvalid;
        unique case (rd_state)
            rd_idle: begin
                if (s_axi_arvalid && s_axi_arready) begin
                    next_ar_idx = s_axi_araddr[7:2];
                    next_rd_state = rd_fetch;
                end
            end
            rd_fetch: next_rd_state = rd_load;
            rd_load: begin
                next_rd_state = rd_resp;
                next_rvalid = 1'b1;
                next_rdata = rd_word;
                next_rresp = is_mapped(ar_idx) ? `ADCSS_RESP_OKAY : `ADCSS_RESP_SLVERR;
            end
            rd_resp: begin
                if (s_axi_rready) begin
                    next_rvalid = 1'b0;
                    next_rd_state = rd_idle;
                end
            end
        endcase
        next_arready = next_rd_state == rd_idle;
        if (wr_fire) begin
            unique case (aw_idx)
                `ADCSS_IDX_MODE: next_mode = 16'(merge({16'h0000, mode}, w_data, w_strb));
                `ADCSS_IDX_CMPE: next_compare_enable_bits = NUM_RESULTS'(merge(
                    32'(compare_enable_bits), w_data, w_strb)); // [RQ12] [RQ17]
                `ADCSS_IDX_COMPARE_HIGHER_SELECT: next_compare_higher_select = NUM_RESULTS'(merge(
                    32'(compare_higher_select), w_data, w_strb));
                default: next_mode = mode;
            endcase
        end
        // Conversion capture, stored one cycle later once the slot is read back
        if (conv_done && seq_busy && !abort_wr && !start_wr) begin
            next_pend_valid = 1'b1;
            next_pend_data = 16'(conv_result);
        end
        if (store_now) begin
            next_conversion_counter = conversion_counter + 4'h1; // [RQ9]
            next_pos = pos + 4'h1;
            if (pos == seq_len - 4'h1) begin
                next_sequence_done_flag = 1'b1; // [RQ1]
                next_pos = 4'h0;
                if (!queue_mode) begin
                    next_conversion_counter = 4'h0; // [RQ8]
                end
                next_seq_busy = mode[`ADCSS_BIT_SCAN] & ~mode[`ADCSS_BIT_TRIG_EN]; // [RQ1]
            end
        end
        // Trigger or start write begins a sequence, an abort write ends it
        if (trig_go || start_wr || abort_wr) begin
            next_seq_busy = ~abort_wr; // [RQ11]
            next_pos = 4'h0;
            if (!queue_mode || start_wr || abort_wr) begin
                next_conversion_counter = 4'h0; // [RQ8] [RQ10]
            end
        end
        // Flags: a hardware set wins over a software clear
        next_sequence_done_flag = next_sequence_done_flag | (sequence_done_flag
            & ~(status_w1c[`ADCSS_BIT_DONE] | start_wr
            | (res_rd & auto_flag_clear))); // [RQ2]
        next_trigger_overrun_flag = (mode[`ADCSS_BIT_TRIG_EN] & ~mode[`ADCSS_BIT_TRIG_LEVEL]
            & trig_rise & seq_busy) // [RQ3]
            | (trigger_overrun_flag & ~(status_w1c[`ADCSS_BIT_TRIG_OVR]
            | abort_wr | start_wr)); // [RQ4]
        next_result_overrun_flag = (store_now && in_range
            && !compare_enable_bits[conversion_counter]
            && conversion_complete_flag[conversion_counter]) // [RQ5]
            | (result_overrun_flag & ~(status_w1c[`ADCSS_BIT_RES_OVR]
            | abort_wr | start_wr)); // [RQ6]
        // Complete flags; a start write clears even against a set
        for (int n = 0; n < NUM_RESULTS; n++) begin
            if (store_now && int'(conversion_counter) == n
                && (!compare_enable_bits[n] || cmp_hit)) begin
                next_conversion_complete_flag[n] = 1'b1; // [RQ14]
            end else if (auto_flag_clear && ((res_rd && int'(res_sel_r) == n
                && !compare_enable_bits[n]) || (res_wr && int'(res_sel_w) == n
                && compare_enable_bits[n]))) begin
                next_conversion_complete_flag[n] = 1'b0;
            end else begin
                next_conversion_complete_flag[n] = conversion_complete_flag[n];
            end
        end
        if (start_wr) begin
            next_conversion_complete_flag = '0;
        end
    end
    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_idx <= 6'h00;
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            rd_state <= rd_idle;
            ar_idx <= 6'h00;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
            mode <= `ADCSS_MODE_RESET;
            compare_enable_bits <= '0;
            compare_higher_select <= '0;
            conversion_complete_flag <= '0;
            sequence_done_flag <= 1'b0;
            trigger_overrun_flag <= 1'b0;
            result_overrun_flag <= 1'b0;
            seq_busy <= 1'b0;
            conversion_counter <= 4'h0;
            pos <= 4'h0;
            pend_valid <= 1'b0;
            pend_data <= 16'h0000;
        end else begin
            aw_held <= next_aw_held;
            aw_idx <= next_aw_idx;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            rd_state <= next_rd_state;
            ar_idx <= next_ar_idx;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            mode <= next_mode;
            compare_enable_bits <= next_compare_enable_bits;
            compare_higher_select <= next_compare_higher_select;
            conversion_complete_flag <= next_conversion_complete_flag;
            sequence_done_flag <= next_sequence_done_flag;
            trigger_overrun_flag <= next_trigger_overrun_flag;
            result_overrun_flag <= next_result_overrun_flag;
            seq_busy <= next_seq_busy;
            conversion_counter <= next_conversion_counter;
            pos <= next_pos;
            pend_valid <= next_pend_valid;
            pend_data <= next_pend_data;
        end
    end
endmodule : adcss_top
`default_nettype wire

// *** verif/adcss_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module adcss_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic seq_busy,
    input wire adcss_pkg::adcss_cnt_t conversion_counter
);
    import adcss_pkg::*;
    // ****
    // Checks
    // ****
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic [7:0] ra;
    logic aw;
    assign aw = s_axi_awvalid && s_axi_awready;
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            ra <= s_axi_araddr;
        end
    end
    property p_rd_lat; s_axi_arvalid && s_axi_arready |-> ##3 s_axi_rvalid; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read latency");
    property p_abort; aw && s_axi_awaddr == 8'h20 |-> ##[1:3] !seq_busy; endproperty
    a_abort: assert property (p_abort) else $error("no abort");
    property p_ctl; aw && s_axi_awaddr <= 8'h10 |-> ##[1:3] conversion_counter == 4'h0; endproperty
    a_ctl: assert property (p_ctl) else $error("counter kept");
    property p_start;
        aw && s_axi_awaddr == 8'h14 |-> ##[1:3] seq_busy && conversion_counter == 4'h0;
    endproperty
    a_start: assert property (p_start) else $error("start failed");
    property p_idle;
        !seq_busy && !$past(seq_busy) && !$rose(s_axi_bvalid) |-> $stable(conversion_counter);
    endproperty
    a_idle: assert property (p_idle) else $error("counter moved");
    property p_stat; s_axi_rvalid && ra == 8'h18 |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_rdata[6];
    endproperty
    a_stat: assert property (p_stat) else $error("status spare bits");
    property p_cmpe; s_axi_rvalid && ra == 8'h20 |-> s_axi_rdata[31:10] == 22'h0; endproperty
    a_cmpe: assert property (p_cmpe) else $error("enable spare bits");
    property p_unmap; s_axi_rvalid && ra == 8'h3C |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    c_abort: cover property (aw && s_axi_awaddr == 8'h20 && seq_busy);
    c_done: cover property (s_axi_rvalid && ra == 8'h18 && s_axi_rdata[7]);
    c_end: cover property ($fell(seq_busy));
endmodule : adcss_checker
bind adcss_top adcss_checker u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_bvalid, .s_axi_rvalid, .s_axi_rdata,
    .s_axi_rresp, .seq_busy, .conversion_counter);
`default_nettype wire

// *** verif/adc_sequence_status_and_compare_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module adc_sequence_status_and_compare_test;
    import adcss_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, trig_pin = 1'b0, conv_done = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [9:0] conv_result = 10'h000;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, seq_busy;
    logic [1:0] s_axi_bresp, s_axi_rresp, br, rr;
    adcss_cnt_t conversion_counter;
    int miscompares = 0, n_checks = 0, cycles = 0;
    adcss_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .trig_pin, .conv_done, .conv_result, .seq_busy, .conversion_counter);
    always #50 aclk = ~aclk;
    // ****
    // Bus and converter tasks
    // ****
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("Error at %0t: saw %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic stop_test();
        if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        br = s_axi_bresp;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rv = s_axi_rdata;
        rr = s_axi_rresp;
    endtask : rd
    task automatic conv(input logic [9:0] r);
        conv_done <= 1'b1;
        conv_result <= r;
        @(posedge aclk);
        conv_done <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask : conv
    // ****
    // Scenarios
    // ****
    task automatic t_reset();
        rd(8'h0C);
        chk(rv, 32'h100);
        rd(8'h18);
        chk(rv, 32'h0);
        rd(8'h3C);
        chk(rr, 2'h2);
        wr(8'h3C, 32'h0);
        chk(br, 2'h2);
    endtask : t_reset
    task automatic t_scan();
        wr(8'h0C, 32'h201);
        wr(8'h14, 32'h0);
        conv(10'h011);
        conv(10'h022);
        conv(10'h033);
        rd(8'h18);
        chk(rv, 32'h91);
        wr(8'h18, 32'hFF);
        rd(8'h18);
        chk(rv, 32'h01);
        wr(8'h20, 32'h0);
        chk(seq_busy, 1'b0);
        chk(conversion_counter, 4'h0);
    endtask : t_scan
    task automatic t_queue();
        wr(8'h0C, 32'h3);
        wr(8'h14, 32'h0);
        for (int i = 0; i < 17; i++) conv(10'(i));
        chk(conversion_counter, 4'h1);
        wr(8'h0C, 32'h200);
        wr(8'h14, 32'h0);
        conv(10'h001);
        conv(10'h002);
        chk(conversion_counter, 4'h0);
    endtask : t_queue
    task automatic t_cmp();
        wr(8'h20, 32'hFFFFFFFF);
        rd(8'h20);
        chk(rv, 32'h3FF);
        wr(8'h20, 32'h1);
        wr(8'h40, 32'h64);
        wr(8'h0C, 32'h100);
        for (int i = 0; i < 4; i++) begin
            wr(8'h38, 32'(i / 2));
            wr(8'h14, 32'h0);
            conv(10'(100 + i % 2));
            rd(8'h28);
            chk(rv[0], 1'((i / 2) == (i % 2)));
        end
        rd(8'h40);
        chk(rv, 32'h64);
        wr(8'h20, 32'h0);
    endtask : t_cmp
    task automatic t_trig();
        wr(8'h0C, 32'h210);
        trig_pin <= 1'b1;
        repeat (6) @(posedge aclk);
        chk(seq_busy, 1'b1);
        trig_pin <= 1'b0;
        repeat (3) @(posedge aclk);
        trig_pin <= 1'b1;
        repeat (6) @(posedge aclk);
        trig_pin <= 1'b0;
        rd(8'h18);
        chk(rv[5], 1'b1);
        wr(8'h00, 32'h0);
        rd(8'h18);
        chk(rv[5], 1'b0);
        trig_pin <= 1'b1;
        repeat (4) @(posedge aclk);
        wr(8'h0C, 32'h118);
        repeat (2) @(posedge aclk);
        chk(seq_busy, 1'b1);
        trig_pin <= 1'b0;
    endtask : t_trig
    task automatic t_auto();
        wr(8'h0C, 32'h104);
        wr(8'h14, 32'h0);
        conv(10'h005);
        rd(8'h18);
        chk(rv[7], 1'b1);
        rd(8'h40);
        rd(8'h18);
        chk(rv[7], 1'b0);
        wr(8'h14, 32'h0);
        conv(10'h006);
        wr(8'h14, 32'h0);
        rd(8'h18);
        chk(rv[7], 1'b0);
    endtask : t_auto
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset();
        t_scan();
        t_queue();
        t_cmp();
        t_trig();
        t_auto();
        stop_test();
    end
endmodule : adc_sequence_status_and_compare_test
`default_nettype wire
